/* shared/fqsc_pkg.sv */
// Purpose: Shared constants and types for the FPU queue sideband link
// Assumes: One clock shared by processor and FPU ends
// Notes: Queue depths are small fixed values chosen for this block
package fqsc_pkg;
	localparam int FQSC_DW = 64;
	localparam int FQSC_QDEPTH = 8;
	localparam int FQSC_PW = 3;
	localparam int FQSC_RF_ENTRIES = 32;
	localparam int FQSC_RA_W = 5;
	localparam int FQSC_TBUS_W = 72;
	localparam int FQSC_TBUS_LAT = 2;
	localparam logic [FQSC_PW-1:0] FQSC_PTR_ONE = 3'h1;
	localparam logic [FQSC_PW-1:0] FQSC_PTR_TWO = 3'h2;
	localparam logic [FQSC_PW:0] FQSC_CNT_ONE = 4'h1;
	localparam logic [FQSC_PW:0] FQSC_CNT_TWO = 4'h2;
	localparam logic [FQSC_PW:0] FQSC_CNT_FULL = 4'h8;
	localparam logic [1:0] FQSC_TB_ONE = 2'h1;
	localparam logic [1:0] FQSC_TB_LAST = 2'h2;
	localparam logic [4:0] FQSC_EXC_NONE = 5'h00;
	typedef logic [FQSC_DW-1:0] fqsc_dword_t;
	typedef enum logic [0:0] {
		FQSC_TB_IDLE = 1'b0,
		FQSC_TB_WAIT = 1'b1
	} fqsc_tb_state_t;
endpackage

/* shared/fqsc_if.sv */
// Purpose: Sideband pins between processor end and FPU end
// Assumes: All signals synchronous to the shared clock
// Notes: Active-low pins carry the _n suffix
interface fqsc_if;
	import fqsc_pkg::*;
	logic exception_debug_n;
	logic store_pop_even_n;
	logic store_pop_odd_n;
	logic load_push_even_n;
	logic load_push_odd_n;
	logic load_push_odd_first_n;
	fqsc_dword_t load_data_even;
	fqsc_dword_t load_data_odd;
	fqsc_dword_t store_data_even;
	fqsc_dword_t store_data_odd;
	logic fp_exception_irq_n;
	logic shared_bus_out_en_n;
	logic [FQSC_TBUS_W-1:0] shared_bus_data;
	logic shared_bus_data_oe;
	modport cpu (
		output exception_debug_n, store_pop_even_n, store_pop_odd_n,
		output load_push_even_n, load_push_odd_n, load_push_odd_first_n,
		output load_data_even, load_data_odd, shared_bus_out_en_n,
		input store_data_even, store_data_odd, fp_exception_irq_n,
		input shared_bus_data, shared_bus_data_oe
	);
	modport fpu (
		input exception_debug_n, store_pop_even_n, store_pop_odd_n,
		input load_push_even_n, load_push_odd_n, load_push_odd_first_n,
		input load_data_even, load_data_odd, shared_bus_out_en_n,
		output store_data_even, store_data_odd, fp_exception_irq_n,
		output shared_bus_data, shared_bus_data_oe
	);
endinterface

/* hw/fqsc_cpu_end.sv */
// Purpose: Processor end: drives the sideband strobes from user requests
// Assumes: User requests are one-cycle pulses synchronous to clk_in
// Notes: Every pin is registered; strobes follow requests by one cycle
module fqsc_cpu_end
	import fqsc_pkg::*;
(
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic debug_mode_in,
	input wire logic pop_even_req_in,
	input wire logic pop_odd_req_in,
	input wire logic push_even_req_in,
	input wire logic push_odd_req_in,
	input wire logic push_odd_first_in,
	input wire fqsc_dword_t push_even_data_in,
	input wire fqsc_dword_t push_odd_data_in,
	input wire logic bus_read_req_in,
	output fqsc_dword_t pop_even_data_out,
	output fqsc_dword_t pop_odd_data_out,
	output logic pop_even_valid_out,
	output logic pop_odd_valid_out,
	output logic [FQSC_TBUS_W-1:0] bus_read_data_out,
	output logic bus_read_valid_out,
	output logic fp_irq_out,
	fqsc_if.cpu link
);
	logic pe_q, po_q, tb_v0_q, tb_v1_q;

	////////////////////////////////////////////////////////////////////
	// Strobes and mode pin, registered so each request is one edge
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			link.exception_debug_n <= 1'b1;
			link.store_pop_even_n <= 1'b1;
			link.store_pop_odd_n <= 1'b1;
			link.load_push_even_n <= 1'b1;
			link.load_push_odd_n <= 1'b1;
			link.load_push_odd_first_n <= 1'b1;
			link.load_data_even <= '0;
			link.load_data_odd <= '0;
			link.shared_bus_out_en_n <= 1'b1;
		end else begin
			link.exception_debug_n <= ~debug_mode_in;
			link.store_pop_even_n <= ~pop_even_req_in;
			link.store_pop_odd_n <= ~pop_odd_req_in;
			link.load_push_even_n <= ~push_even_req_in;
			link.load_push_odd_n <= ~push_odd_req_in;
			link.load_push_odd_first_n <= ~push_odd_first_in;
			link.load_data_even <= push_even_data_in;
			link.load_data_odd <= push_odd_data_in;
			link.shared_bus_out_en_n <= ~bus_read_req_in;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Capture popped data and bus data at their fixed latency
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			pe_q <= 1'b0;
			po_q <= 1'b0;
			tb_v0_q <= 1'b0;
			tb_v1_q <= 1'b0;
			pop_even_data_out <= '0;
			pop_odd_data_out <= '0;
			pop_even_valid_out <= 1'b0;
			pop_odd_valid_out <= 1'b0;
			bus_read_data_out <= '0;
			bus_read_valid_out <= 1'b0;
			fp_irq_out <= 1'b0;
		end else begin
			pe_q <= ~link.store_pop_even_n;
			po_q <= ~link.store_pop_odd_n;
			pop_even_valid_out <= pe_q;
			pop_odd_valid_out <= po_q;
			if (pe_q) begin
				pop_even_data_out <= link.store_data_even;
			end
			if (po_q) begin
				pop_odd_data_out <= link.store_data_odd;
			end
			// Sample two cycles after the enable went low
			tb_v0_q <= ~link.shared_bus_out_en_n;
			tb_v1_q <= tb_v0_q;
			bus_read_valid_out <= tb_v1_q;
			if (tb_v1_q) begin
				bus_read_data_out <= link.shared_bus_data;
			end
			fp_irq_out <= ~link.fp_exception_irq_n;
		end
	end
endmodule

/* hw/fqsc_fpu_end.sv */
// Purpose: FPU end: queues, exception write policy, interrupt, bus answer
// Assumes: Strobes are sampled once per clock edge
// Notes: Load queue overflow drops the push; store queue underflow pops return stale data
//
// Function
// - Debug low: enabled exception blocks register write
// - Debug low: disabled exception writes substitution value
// - Debug high: every exception writes substitution
// - Even pop strobe reads even store doubleword
// - Odd pop strobe reads odd store doubleword
// - Push strobe enqueues load doubleword, bumps pointer
// - Priority low: odd enqueued before even
// - Enabled exception asserts interrupt low
// - Bus data valid two cycles after enable
module fqsc_fpu_end
	import fqsc_pkg::*;
(
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic op_done_in,
	input wire logic [FQSC_RA_W-1:0] op_dest_in,
	input wire fqsc_dword_t op_result_in,
	input wire fqsc_dword_t op_subst_in,
	input wire logic [4:0] op_exc_in,
	input wire logic [4:0] exc_enable_in,
	input wire logic store_push_in,
	input wire logic store_push_odd_in,
	input wire fqsc_dword_t store_push_data_in,
	input wire logic load_pop_in,
	input wire logic [FQSC_TBUS_W-1:0] bus_reply_in,
	output fqsc_dword_t load_pop_data_out,
	output logic load_pop_valid_out,
	output logic [FQSC_PW:0] load_count_out,
	output logic rf_write_out,
	output logic [FQSC_RA_W-1:0] rf_addr_out,
	output fqsc_dword_t rf_data_out,
	fqsc_if.fpu link
);
	fqsc_dword_t lq_mem [FQSC_QDEPTH];
	fqsc_dword_t sq_even [FQSC_QDEPTH];
	fqsc_dword_t sq_odd [FQSC_QDEPTH];
	fqsc_dword_t rf_mem [FQSC_RF_ENTRIES];
	logic [FQSC_PW-1:0] lq_wr_q, lq_rd_q;
	logic [FQSC_PW:0] lq_cnt_q;
	logic [FQSC_PW-1:0] se_wr_q, se_rd_q, so_wr_q, so_rd_q;
	logic pe, po, lpop, exc_any, exc_en;
	logic [FQSC_PW:0] lq_add;
	fqsc_tb_state_t tb_state_q;
	logic [1:0] tb_cnt_q;

	////////////////////////////////////////////////////////////////////
	// Pointer step used by every queue
	function automatic logic [FQSC_PW-1:0] fqsc_step(
		input logic [FQSC_PW-1:0] p, input logic [FQSC_PW-1:0] n);
		fqsc_step = p + n;
	endfunction

	////////////////////////////////////////////////////////////////////
	// Load queue push decode; full queue drops the push silently
	always_comb begin
		pe = ~link.load_push_even_n;
		po = ~link.load_push_odd_n;
		lpop = load_pop_in && (lq_cnt_q != '0);
		lq_add = '0;
		if (pe && po) begin
			lq_add = FQSC_CNT_TWO;
		end else if (pe || po) begin
			lq_add = FQSC_CNT_ONE;
		end
		if (lq_cnt_q + lq_add > FQSC_CNT_FULL + {3'h0, lpop}) begin
			lq_add = '0;
		end
	end

	// Load queue write ordering and pointers
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			lq_wr_q <= '0;
			lq_rd_q <= '0;
			lq_cnt_q <= '0;
		end else begin
			if (lq_add == FQSC_CNT_TWO) begin
				if (!link.load_push_odd_first_n) begin
					lq_mem[lq_wr_q] <= link.load_data_odd;
					lq_mem[fqsc_step(lq_wr_q, FQSC_PTR_ONE)] <=
						link.load_data_even;
				end else begin
					lq_mem[lq_wr_q] <= link.load_data_even;
					lq_mem[fqsc_step(lq_wr_q, FQSC_PTR_ONE)] <=
						link.load_data_odd;
				end
				lq_wr_q <= fqsc_step(lq_wr_q, FQSC_PTR_TWO);
			end else if (lq_add == FQSC_CNT_ONE) begin
				lq_mem[lq_wr_q] <= pe ? link.load_data_even
					: link.load_data_odd;
				lq_wr_q <= fqsc_step(lq_wr_q, FQSC_PTR_ONE);
			end
			if (lpop) begin
				lq_rd_q <= fqsc_step(lq_rd_q, FQSC_PTR_ONE);
			end
			lq_cnt_q <= lq_cnt_q + lq_add - {3'h0, lpop};
		end
	end

	// Load queue read side toward the execution units
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			load_pop_data_out <= '0;
			load_pop_valid_out <= 1'b0;
			load_count_out <= '0;
		end else begin
			load_pop_valid_out <= lpop;
			if (lpop) begin
				load_pop_data_out <= lq_mem[lq_rd_q];
			end
			load_count_out <= lq_cnt_q;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Store queues: one per bank, each pop strobe advances one pointer
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			se_wr_q <= '0;
			se_rd_q <= '0;
			so_wr_q <= '0;
			so_rd_q <= '0;
			link.store_data_even <= '0;
			link.store_data_odd <= '0;
		end else begin
			if (store_push_in && !store_push_odd_in) begin
				sq_even[se_wr_q] <= store_push_data_in;
				se_wr_q <= fqsc_step(se_wr_q, FQSC_PTR_ONE);
			end
			if (store_push_in && store_push_odd_in) begin
				sq_odd[so_wr_q] <= store_push_data_in;
				so_wr_q <= fqsc_step(so_wr_q, FQSC_PTR_ONE);
			end
			if (!link.store_pop_even_n) begin
				link.store_data_even <= sq_even[se_rd_q];
				se_rd_q <= fqsc_step(se_rd_q, FQSC_PTR_ONE);
			end
			if (!link.store_pop_odd_n) begin
				link.store_data_odd <= sq_odd[so_rd_q];
				so_rd_q <= fqsc_step(so_rd_q, FQSC_PTR_ONE);
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// Exception write policy and interrupt
	always_comb begin
		exc_any = op_exc_in != FQSC_EXC_NONE;
		exc_en = (op_exc_in & exc_enable_in) != FQSC_EXC_NONE;
	end

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			rf_write_out <= 1'b0;
			rf_addr_out <= '0;
			rf_data_out <= '0;
			link.fp_exception_irq_n <= 1'b1;
		end else begin
			rf_write_out <= 1'b0;
			rf_addr_out <= op_dest_in;
			if (op_done_in) begin
				if (!exc_any) begin
					rf_write_out <= 1'b1;
					rf_data_out <= op_result_in;
				end else if (!link.exception_debug_n && exc_en) begin
					rf_write_out <= 1'b0;
				end else begin
					// Debug low with disabled exception, or debug high
					rf_write_out <= 1'b1;
					rf_data_out <= op_subst_in;
				end
			end
			// Irq holds until next op completes; a simple level scheme
			if (op_done_in) begin
				link.fp_exception_irq_n <= ~exc_en;
			end
		end
	end

	// Register file image
	always_ff @(posedge clk_in) begin
		if (rf_write_out) begin
			rf_mem[rf_addr_out] <= rf_data_out;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Shared bus answer: drive data for the second edge after enable
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			tb_state_q <= FQSC_TB_IDLE;
			tb_cnt_q <= '0;
			link.shared_bus_data <= '0;
			link.shared_bus_data_oe <= 1'b0;
		end else begin
			case (tb_state_q)
				FQSC_TB_IDLE: begin
					link.shared_bus_data_oe <= 1'b0;
					if (!link.shared_bus_out_en_n) begin
						tb_state_q <= FQSC_TB_WAIT;
						tb_cnt_q <= FQSC_TB_ONE;
						link.shared_bus_data <= bus_reply_in;
						link.shared_bus_data_oe <= 1'b1;
					end
				end
				FQSC_TB_WAIT: begin
					tb_cnt_q <= tb_cnt_q + FQSC_TB_ONE;
					if (tb_cnt_q == FQSC_TB_LAST) begin
						tb_state_q <= FQSC_TB_IDLE;
						link.shared_bus_data_oe <= 1'b0;
					end
				end
				default: begin
					tb_state_q <= FQSC_TB_IDLE;
				end
			endcase
		end
	end
endmodule

/* dv/fqsc_monitor.sv */
// Purpose: Concurrent checks on the sideband pins between both ends
// Assumes: One clock domain, asynchronous active-high reset
// Notes: Sees the link pins only, never the user sides
module fqsc_monitor
	import fqsc_pkg::*;
(
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic exception_debug_n,
	input wire logic store_pop_even_n,
	input wire logic store_pop_odd_n,
	input wire logic load_push_even_n,
	input wire logic load_push_odd_n,
	input wire fqsc_dword_t store_data_even,
	input wire fqsc_dword_t store_data_odd,
	input wire logic fp_exception_irq_n,
	input wire logic shared_bus_out_en_n,
	input wire logic shared_bus_data_oe
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (rst_in);
	////////////////////////////////////////////////////////////////////////////
	// Bus answer: request seen while idle, then two driven cycles
	sequence bus_req_s;
		!shared_bus_out_en_n && !shared_bus_data_oe;
	endsequence
	sequence bus_burst_s;
		shared_bus_data_oe [*2] ##1 !shared_bus_data_oe;
	endsequence
	a_even_pop_hold: assert property (
		store_pop_even_n |=> $stable(store_data_even)) else $error("even moved");
	a_odd_pop_hold: assert property (
		store_pop_odd_n |=> $stable(store_data_odd)) else $error("odd moved");
	a_bus_answer: assert property (
		bus_req_s |=> bus_burst_s) else $error("bus burst wrong");
	a_bus_cause: assert property (
		$rose(shared_bus_data_oe) |-> !$past(shared_bus_out_en_n))
		else $error("bus driven unasked");
	a_bus_busy_len: assert property (
		shared_bus_data_oe [*2] |=> !shared_bus_data_oe)
		else $error("bus driven too long");
	// Strobes idle when reset lets go, so no spurious queue operation
	a_reset_strobes: assert property (
		$fell(rst_in) |-> store_pop_even_n && store_pop_odd_n
		&& load_push_even_n && load_push_odd_n) else $error("strobe at reset");
	a_reset_irq: assert property (
		$fell(rst_in) |-> fp_exception_irq_n) else $error("irq at reset");
	a_reset_debug: assert property (
		$fell(rst_in) |-> exception_debug_n) else $error("debug at reset");
endmodule

/* dv/fpu_queue_sideband_control_tb.sv */
// Purpose: Self-checking bench joining processor end and FPU end
// Assumes: Inputs driven at falling edge, outputs read there too
// Notes: Expected results queue per output stream, watcher pops them
module fpu_queue_sideband_control_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import fqsc_pkg::*;
	logic clk_in = 1'b0;
	logic rst_in = 1'b1;
	logic debug_mode_in, pop_even_req_in, pop_odd_req_in, push_even_req_in;
	logic push_odd_req_in, push_odd_first_in, bus_read_req_in, op_done_in;
	logic store_push_in, store_push_odd_in, load_pop_in, fp_irq_out;
	logic pop_even_valid_out, pop_odd_valid_out, bus_read_valid_out;
	logic load_pop_valid_out, rf_write_out;
	fqsc_dword_t push_even_data_in, push_odd_data_in, op_result_in;
	fqsc_dword_t op_subst_in, store_push_data_in, pop_even_data_out;
	fqsc_dword_t pop_odd_data_out, load_pop_data_out, rf_data_out;
	logic [FQSC_RA_W-1:0] op_dest_in, rf_addr_out;
	logic [4:0] op_exc_in, exc_enable_in;
	logic [FQSC_TBUS_W-1:0] bus_reply_in, bus_read_data_out;
	logic [FQSC_PW:0] load_count_out;
	logic [71:0] exp_q[5][$];
	int err_count = 0;
	int total_checks = 0;
	int seed = 32'h2CB5E693;
	int c;
	fqsc_if link_if();
	fqsc_cpu_end fqsc_cpu_end_inst (.clk_in, .rst_in, .debug_mode_in,
		.pop_even_req_in, .pop_odd_req_in, .push_even_req_in, .push_odd_req_in,
		.push_odd_first_in, .push_even_data_in, .push_odd_data_in,
		.bus_read_req_in, .pop_even_data_out, .pop_odd_data_out,
		.pop_even_valid_out, .pop_odd_valid_out, .bus_read_data_out,
		.bus_read_valid_out, .fp_irq_out, .link(link_if.cpu));
	fqsc_fpu_end fqsc_fpu_end_inst (.clk_in, .rst_in, .op_done_in, .op_dest_in,
		.op_result_in, .op_subst_in, .op_exc_in, .exc_enable_in, .store_push_in,
		.store_push_odd_in, .store_push_data_in, .load_pop_in, .bus_reply_in,
		.load_pop_data_out, .load_pop_valid_out, .load_count_out, .rf_write_out,
		.rf_addr_out, .rf_data_out, .link(link_if.fpu));
	fqsc_monitor fqsc_monitor_inst (.clk_in(clk_in), .rst_in(rst_in),
		.exception_debug_n(link_if.exception_debug_n),
		.store_pop_even_n(link_if.store_pop_even_n),
		.store_pop_odd_n(link_if.store_pop_odd_n),
		.load_push_even_n(link_if.load_push_even_n),
		.load_push_odd_n(link_if.load_push_odd_n),
		.store_data_even(link_if.store_data_even),
		.store_data_odd(link_if.store_data_odd),
		.fp_exception_irq_n(link_if.fp_exception_irq_n),
		.shared_bus_out_en_n(link_if.shared_bus_out_en_n),
		.shared_bus_data_oe(link_if.shared_bus_data_oe));
	////////////////////////////////////////////////////////////////////////////
	// Clock at 40 MHz
	initial begin
		forever #12.5 clk_in = ~clk_in;
	end
	task automatic tick(input int n);
		repeat (n) @(negedge clk_in);
	endtask
	task automatic chk(input logic [71:0] seen, input logic [71:0] exp);
		total_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	// An empty queue yields unknown, so any surprise result is a mismatch
	function automatic logic [71:0] nxt(input int s);
		if (exp_q[s].size() == 0) return 'x;
		return exp_q[s].pop_front();
	endfunction
	task automatic final_report();
		$display("Checks %0d mismatches %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	// Watcher: each valid pulse consumes the oldest note of its stream
	always @(negedge clk_in) begin
		if (pop_even_valid_out === 1'b1) begin
			chk(72'(pop_even_data_out), nxt(0));
		end
		if (pop_odd_valid_out === 1'b1) begin
			chk(72'(pop_odd_data_out), nxt(1));
		end
		if (load_pop_valid_out === 1'b1) begin
			chk(72'(load_pop_data_out), nxt(2));
		end
		if (rf_write_out === 1'b1) begin
			chk({3'h0, rf_addr_out, rf_data_out}, nxt(3));
		end
		if (bus_read_valid_out === 1'b1) begin
			chk(bus_read_data_out, nxt(4));
		end
	end
	// Watchdog: the tests need a few hundred cycles at most
	initial begin
		#100us;
		err_count++;
		final_report();
	end
	////////////////////////////////////////////////////////////////////////////
	initial begin
		{debug_mode_in, pop_even_req_in, pop_odd_req_in, push_even_req_in} = '0;
		{push_odd_req_in, push_odd_first_in, bus_read_req_in, op_done_in} = '0;
		{store_push_in, store_push_odd_in, load_pop_in, op_exc_in} = '0;
		{push_even_data_in, push_odd_data_in, op_result_in, op_subst_in} = '0;
		{store_push_data_in, op_dest_in, exc_enable_in, bus_reply_in} = '0;
		tick(6);
		rst_in = 1'b0;
		// Store banks filled alternately, then popped back to back
		for (int i = 0; i < 4; i++) begin
			tick(1);
			store_push_in = 1'b1;
			store_push_odd_in = i[0];
			store_push_data_in = {$random(seed), $random(seed)};
			exp_q[i[0]].push_back(72'(store_push_data_in));
		end
		tick(1);
		store_push_in = 1'b0;
		for (int i = 0; i < 4; i++) begin
			pop_even_req_in = !i[0];
			pop_odd_req_in = i[0];
			tick(1);
		end
		{pop_even_req_in, pop_odd_req_in} = 2'h0;
		// Both load banks in one cycle, in each priority order
		for (int p = 0; p < 2; p++) begin
			tick(1);
			{push_even_req_in, push_odd_req_in, push_odd_first_in} = {2'h3, p[0]};
			push_even_data_in = {$random(seed), $random(seed)};
			push_odd_data_in = {$random(seed), $random(seed)};
			if (p == 1) exp_q[2].push_back(72'(push_odd_data_in));
			exp_q[2].push_back(72'(push_even_data_in));
			if (p == 0) exp_q[2].push_back(72'(push_odd_data_in));
		end
		// Single bank pushes take one slot each, priority ignored
		tick(1);
		{push_even_req_in, push_odd_req_in} = 2'h2;
		push_even_data_in = {$random(seed), $random(seed)};
		exp_q[2].push_back(72'(push_even_data_in));
		tick(1);
		{push_even_req_in, push_odd_req_in} = 2'h1;
		push_odd_data_in = {$random(seed), $random(seed)};
		exp_q[2].push_back(72'(push_odd_data_in));
		tick(1);
		{push_even_req_in, push_odd_req_in} = 2'h0;
		tick(4);
		chk(72'(load_count_out), 72'h6);
		load_pop_in = 1'b1;
		tick(6);
		load_pop_in = 1'b0;
		// No, disabled and enabled exception, debug off then on
		for (int k = 0; k < 6; k++) begin
			c = k % 3;
			debug_mode_in = (k > 2);
			tick(3);
			{op_done_in, op_dest_in} = {1'b1, 5'($random(seed))};
			op_result_in = {$random(seed), $random(seed)};
			op_subst_in = {$random(seed), $random(seed)};
			op_exc_in = (c == 0) ? FQSC_EXC_NONE : 5'h04;
			exc_enable_in = (c == 2) ? 5'h14 : 5'h11;
			if (c == 0) exp_q[3].push_back({3'h0, op_dest_in, op_result_in});
			else if (c == 1 || k < 3)
				exp_q[3].push_back({3'h0, op_dest_in, op_subst_in});
			tick(1);
			op_done_in = 1'b0;
			tick(4);
			chk(72'(fp_irq_out), 72'(c == 2));
		end
		// Shared bus reads with the reply held steady
		for (int b = 0; b < 2; b++) begin
			bus_reply_in = 72'({$random(seed), $random(seed), $random(seed)});
			exp_q[4].push_back(bus_reply_in);
			bus_read_req_in = 1'b1;
			tick(1);
			bus_read_req_in = 1'b0;
			tick(7);
		end
		tick(5);
		for (int s = 0; s < 5; s++) chk(72'(exp_q[s].size()), 72'h0);
		final_report();
	end
endmodule
